// ### gpfm_board.sv
// gpfm_board.sv: board logic on the four general pins
// assumes: device enables decide who drives each pin wire
`timescale 1ns/1ps
`default_nettype none
module gpfm_board (
  // device side
  input  wire logic [3:0] dev_level_in,
  input  wire logic [3:0] dev_enable_in,
  // board drive
  input  wire logic [3:0] drive_in,
  output logic      [3:0] wire_level_out
);
  // ==========================================================================
  // wire level: device wins where it drives
  assign wire_level_out = (dev_enable_in & dev_level_in) | (~dev_enable_in & drive_in);
endmodule
`default_nettype wire

// ### gpfm_defs.svh
// gpfm_defs.svh: register offsets, field positions, reset values and function codes
// assumes: included by bare name from the package and the pin function mux module
`ifndef GPFM_DEFS_SVH
`define GPFM_DEFS_SVH

// ==========================================================================
// register offsets
`define GPFM_ADDR_PIN_DIRECTION   12'h06E
`define GPFM_ADDR_IN_SEL_PLANE2   12'h06F
`define GPFM_ADDR_IN_SEL_PLANE1   12'h070
`define GPFM_ADDR_IN_SEL_PLANE0   12'h071
`define GPFM_ADDR_OUT_SEL_PLANE2  12'h072
`define GPFM_ADDR_OUT_SEL_PLANE1  12'h073
`define GPFM_ADDR_OUT_SEL_PLANE0  12'h074
`define GPFM_ADDR_RESERVED_GAP    12'h075
`define GPFM_ADDR_OUT_DRIVE       12'h076
`define GPFM_ADDR_IN_LEVELS       12'h219

// ==========================================================================
// field layout and reset values
`define GPFM_FIELD_LSB            0
`define GPFM_FIELD_MSB            3
`define GPFM_RESET_FIELD          4'h0
`define GPFM_RESERVED_READ        4'h0

// ==========================================================================
// function codes
`define GPFM_SEL_GENERAL          3'h0
`define GPFM_SEL_CODE1            3'h1
`define GPFM_SEL_CODE2            3'h2
`define GPFM_SEL_REF_CHOICE       3'h5

`endif

// ### gpfm_general_pin_function_mux.sv
// gpfm_general_pin_function_mux.sv: four general pins with register-set direction and function
// assumes: plain register port, read data one cycle after the read strobe; status flags
// come from logic on clock_in; the pin wire level is resolved outside from the enables
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpfm_defs.svh"
module gpfm_general_pin_function_mux (
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_n_in,
  // register port
  input  wire gpfm_pkg::gpfm_addr_t  reg_addr_in,
  input  wire gpfm_pkg::gpfm_data_t  reg_wdata_in,
  input  wire logic                  reg_write_in,
  input  wire logic                  reg_read_in,
  output gpfm_pkg::gpfm_data_t       reg_rdata_out,
  // general pins
  input  wire gpfm_pkg::gpfm_pins_t  pin_in,
  output gpfm_pkg::gpfm_pins_t       pin_out,
  output gpfm_pkg::gpfm_pins_t       pin_oe_out,
  // internal status flags
  input  wire logic                  loss_of_lock_in,
  input  wire logic                  holdover_in,
  input  wire logic                  ref0_loss_in,
  input  wire logic                  ref1_loss_in,
  // controls to the rest of the device
  output gpfm_pkg::gpfm_clk_en_t     clock_out_enable_out,
  output gpfm_pkg::gpfm_clk_en_t     clock_out_enable_valid_out,
  output logic                       manual_reference_choice_out,
  output logic                       manual_reference_valid_out
);
  import gpfm_pkg::*;

  // ==========================================================================
  // state
  gpfm_pins_t   dir_ff,      nxt_dir;
  gpfm_pins_t   in_p2_ff,    nxt_in_p2;
  gpfm_pins_t   in_p1_ff,    nxt_in_p1;
  gpfm_pins_t   in_p0_ff,    nxt_in_p0;
  gpfm_pins_t   out_p2_ff,   nxt_out_p2;
  gpfm_pins_t   out_p1_ff,   nxt_out_p1;
  gpfm_pins_t   out_p0_ff,   nxt_out_p0;
  gpfm_pins_t   out_val_ff,  nxt_out_val;
  gpfm_pins_t   in_val_ff,   nxt_in_val;
  gpfm_data_t   rdata_ff,    nxt_rdata;
  gpfm_pins_t   pin_ff,      nxt_pin;
  gpfm_pins_t   oe_ff,       nxt_oe;
  gpfm_clk_en_t clk_en_ff,   nxt_clk_en;
  gpfm_clk_en_t clk_vld_ff,  nxt_clk_vld;
  logic         ref_ff,      nxt_ref;
  logic         ref_vld_ff,  nxt_ref_vld;
  gpfm_pins_t   pin_sync;

  // selects gathered from their bit planes
  function automatic gpfm_sel_t plane_sel(input gpfm_pins_t p2, input gpfm_pins_t p1,
                                          input gpfm_pins_t p0, input int idx);
    plane_sel = {p2[idx], p1[idx], p0[idx]};
  endfunction

  function automatic gpfm_data_t pad_field(input gpfm_pins_t v);
    pad_field = {`GPFM_RESERVED_READ, v};
  endfunction

  // ==========================================================================
  // pin level synchroniser
  gpfm_pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ==========================================================================
  // register file
  always_comb begin
    nxt_dir     = dir_ff;
    nxt_in_p2   = in_p2_ff;
    nxt_in_p1   = in_p1_ff;
    nxt_in_p0   = in_p0_ff;
    nxt_out_p2  = out_p2_ff;
    nxt_out_p1  = out_p1_ff;
    nxt_out_p0  = out_p0_ff;
    nxt_out_val = out_val_ff;
    nxt_rdata   = 8'h00;
    if (reg_write_in) begin
      case (reg_addr_in)
        `GPFM_ADDR_PIN_DIRECTION:  nxt_dir = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_IN_SEL_PLANE2:  nxt_in_p2 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_IN_SEL_PLANE1:  nxt_in_p1 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_IN_SEL_PLANE0:  nxt_in_p0 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_OUT_SEL_PLANE2: nxt_out_p2 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_OUT_SEL_PLANE1: nxt_out_p1 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_OUT_SEL_PLANE0: nxt_out_p0 = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        `GPFM_ADDR_OUT_DRIVE:      nxt_out_val = reg_wdata_in[`GPFM_FIELD_MSB:`GPFM_FIELD_LSB];
        default: begin
        end
      endcase
    end
    if (reg_read_in) begin
      case (reg_addr_in)
        `GPFM_ADDR_PIN_DIRECTION:  nxt_rdata = pad_field(dir_ff);
        `GPFM_ADDR_IN_SEL_PLANE2:  nxt_rdata = pad_field(in_p2_ff);
        `GPFM_ADDR_IN_SEL_PLANE1:  nxt_rdata = pad_field(in_p1_ff);
        `GPFM_ADDR_IN_SEL_PLANE0:  nxt_rdata = pad_field(in_p0_ff);
        `GPFM_ADDR_OUT_SEL_PLANE2: nxt_rdata = pad_field(out_p2_ff);
        `GPFM_ADDR_OUT_SEL_PLANE1: nxt_rdata = pad_field(out_p1_ff);
        `GPFM_ADDR_OUT_SEL_PLANE0: nxt_rdata = pad_field(out_p0_ff);
        `GPFM_ADDR_OUT_DRIVE:      nxt_rdata = pad_field(out_val_ff);
        `GPFM_ADDR_IN_LEVELS:      nxt_rdata = pad_field(in_val_ff);
        default:                   nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      dir_ff     <= `GPFM_RESET_FIELD;
      in_p2_ff   <= `GPFM_RESET_FIELD;
      in_p1_ff   <= `GPFM_RESET_FIELD;
      in_p0_ff   <= `GPFM_RESET_FIELD;
      out_p2_ff  <= `GPFM_RESET_FIELD;
      out_p1_ff  <= `GPFM_RESET_FIELD;
      out_p0_ff  <= `GPFM_RESET_FIELD;
      out_val_ff <= `GPFM_RESET_FIELD;
      rdata_ff   <= 8'h00;
    end else begin
      dir_ff     <= nxt_dir;
      in_p2_ff   <= nxt_in_p2;
      in_p1_ff   <= nxt_in_p1;
      in_p0_ff   <= nxt_in_p0;
      out_p2_ff  <= nxt_out_p2;
      out_p1_ff  <= nxt_out_p1;
      out_p0_ff  <= nxt_out_p0;
      out_val_ff <= nxt_out_val;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ==========================================================================
  // pin function mux
  always_comb begin
    gpfm_sel_t isel;
    gpfm_sel_t osel;
    isel        = `GPFM_SEL_GENERAL;
    osel        = `GPFM_SEL_GENERAL;
    nxt_in_val  = in_val_ff;
    nxt_pin     = 4'h0;
    nxt_oe      = 4'h0;
    nxt_clk_en  = 8'h00;
    nxt_clk_vld = 8'h00;
    nxt_ref     = ref_ff;
    nxt_ref_vld = 1'b0;
    for (int i = 0; i < 4; i++) begin
      isel = plane_sel(in_p2_ff, in_p1_ff, in_p0_ff, i);
      osel = plane_sel(out_p2_ff, out_p1_ff, out_p0_ff, i);
      if (!dir_ff[i]) begin
        case (isel)
          `GPFM_SEL_GENERAL: nxt_in_val[i] = pin_sync[i];
          `GPFM_SEL_CODE1: begin
            nxt_clk_en[i]  = pin_sync[i];
            nxt_clk_vld[i] = 1'b1;
          end
          `GPFM_SEL_CODE2: begin
            nxt_clk_en[i + 4]  = pin_sync[i];
            nxt_clk_vld[i + 4] = 1'b1;
          end
          `GPFM_SEL_REF_CHOICE: begin
            if (i == 2) begin
              nxt_ref     = pin_sync[i];
              nxt_ref_vld = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else begin
        nxt_oe[i] = 1'b1;
        if (osel == `GPFM_SEL_GENERAL) begin
          nxt_pin[i] = out_val_ff[i];
        end else begin
          case (i)
            0: nxt_pin[i] = (osel == `GPFM_SEL_CODE1) ? loss_of_lock_in : 1'b0;
            1: nxt_pin[i] = (osel == `GPFM_SEL_CODE1) ? holdover_in : 1'b0;
            2: nxt_pin[i] = (osel == `GPFM_SEL_CODE1) ? ref0_loss_in :
                            (osel == `GPFM_SEL_CODE2) ? ref1_loss_in : 1'b0;
            3: nxt_pin[i] = (osel == `GPFM_SEL_CODE2) ? ref1_loss_in : 1'b0;
            default: nxt_pin[i] = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      in_val_ff  <= 4'h0;
      pin_ff     <= 4'h0;
      oe_ff      <= 4'h0;
      clk_en_ff  <= 8'h00;
      clk_vld_ff <= 8'h00;
      ref_ff     <= 1'b0;
      ref_vld_ff <= 1'b0;
    end else begin
      in_val_ff  <= nxt_in_val;
      pin_ff     <= nxt_pin;
      oe_ff      <= nxt_oe;
      clk_en_ff  <= nxt_clk_en;
      clk_vld_ff <= nxt_clk_vld;
      ref_ff     <= nxt_ref;
      ref_vld_ff <= nxt_ref_vld;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_out               = rdata_ff;
  assign pin_out                     = pin_ff;
  assign pin_oe_out                  = oe_ff;
  assign clock_out_enable_out        = clk_en_ff;
  assign clock_out_enable_valid_out  = clk_vld_ff;
  assign manual_reference_choice_out = ref_ff;
  assign manual_reference_valid_out  = ref_vld_ff;
endmodule
`default_nettype wire

// ### gpfm_general_pin_function_mux_props.sv
// gpfm_general_pin_function_mux_props.sv: checker bound to the pin function mux
// assumes: shadow of the config registers follows the register port writes
`timescale 1ns/1ps
`default_nettype none
module gpfm_mux_props
  import gpfm_pkg::*;
(
  // clock, reset, register port
  input wire logic         clock_in,
  input wire logic         rst_n_in,
  input wire gpfm_addr_t   reg_addr_in,
  input wire gpfm_data_t   reg_wdata_in,
  input wire logic         reg_write_in,
  input wire logic         reg_read_in,
  input wire gpfm_data_t   reg_rdata_out,
  // pins, flags, controls
  input wire gpfm_pins_t   pin_out,
  input wire gpfm_pins_t   pin_oe_out,
  input wire logic         loss_of_lock_in,
  input wire logic         holdover_in,
  input wire logic         ref0_loss_in,
  input wire logic         ref1_loss_in,
  input wire gpfm_clk_en_t clock_out_enable_valid_out,
  input wire logic         manual_reference_choice_out,
  input wire logic         manual_reference_valid_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // shadow of direction, select planes, drive values
  gpfm_pins_t       dir_ff, nxt_dir, oval_ff, nxt_oval;
  gpfm_pins_t [2:0] is_ff, nxt_is, os_ff, nxt_os;
  logic [2:0]       ic, oc;
  gpfm_pins_t       exp_pin;
  gpfm_clk_en_t     exp_val;
  logic             exp_ref;
  always_comb begin
    nxt_dir = dir_ff;
    nxt_oval = oval_ff;
    nxt_is = is_ff;
    nxt_os = os_ff;
    if (reg_write_in) begin
      if (reg_addr_in == 12'h06E) nxt_dir = reg_wdata_in[3:0];
      if (reg_addr_in == 12'h076) nxt_oval = reg_wdata_in[3:0];
      for (int k = 0; k < 3; k++) begin
        if (reg_addr_in == 12'h071 - 12'(k)) nxt_is[k] = reg_wdata_in[3:0];
        if (reg_addr_in == 12'h074 - 12'(k)) nxt_os[k] = reg_wdata_in[3:0];
      end
    end
  end
  always_ff @(posedge clock_in) begin
    dir_ff <= rst_n_in ? nxt_dir : 4'h0;
    oval_ff <= rst_n_in ? nxt_oval : 4'h0;
    is_ff <= rst_n_in ? nxt_is : '0;
    os_ff <= rst_n_in ? nxt_os : '0;
  end
  always_comb begin
    exp_pin = 4'h0;
    exp_val = 8'h00;
    for (int i = 0; i < 4; i++) begin
      ic = {is_ff[2][i], is_ff[1][i], is_ff[0][i]};
      oc = {os_ff[2][i], os_ff[1][i], os_ff[0][i]};
      if (!dir_ff[i] && ic == 3'h1) exp_val[i] = 1'b1;
      if (!dir_ff[i] && ic == 3'h2) exp_val[i+4] = 1'b1;
      if (oc == 3'h0) exp_pin[i] = oval_ff[i];
      if (oc == 3'h1 && i < 3) exp_pin[i] = i == 0 ? loss_of_lock_in : (i == 1 ? holdover_in : ref0_loss_in);
      if (oc == 3'h2 && i > 1) exp_pin[i] = ref1_loss_in;
    end
    exp_ref = !dir_ff[2] && {is_ff[2][2], is_ff[1][2], is_ff[0][2]} == 3'h5;
  end
  // ==========================================================================
  // assertions
  a_dir_to_oe: assert property (1 |=> pin_oe_out == $past(dir_ff))
    else $error("pin enable differs from direction");
  a_dir_readback: assert property (reg_read_in && reg_addr_in == 12'h06E |=> reg_rdata_out[3:0] == $past(dir_ff))
    else $error("direction readback wrong");
  a_pin_drive: assert property (1 |=> ((pin_out ^ $past(exp_pin)) & $past(dir_ff)) == 4'h0)
    else $error("output pin value wrong");
  a_enable_valid: assert property (1 |=> clock_out_enable_valid_out == $past(exp_val))
    else $error("clock enable valid wrong");
  a_ref_valid: assert property (1 |=> manual_reference_valid_out == $past(exp_ref))
    else $error("reference valid wrong");
  a_ref_hold: assert property (!exp_ref |=> $stable(manual_reference_choice_out))
    else $error("reference choice moved");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  a_upper_zero: assert property (reg_read_in |=> reg_rdata_out[7:4] == 4'h0)
    else $error("upper read bits set");
  a_gap_zero: assert property (reg_read_in && reg_addr_in == 12'h075 |=> reg_rdata_out == 8'h00)
    else $error("gap address read not zero");
  c_level_read: cover property (reg_read_in && reg_addr_in == 12'h219);
  c_enable_cfg: cover property (exp_val != 8'h00);
  c_ref_cfg: cover property (exp_ref);
endmodule
bind gpfm_general_pin_function_mux gpfm_mux_props u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .pin_out(pin_out), .pin_oe_out(pin_oe_out), .loss_of_lock_in(loss_of_lock_in), .holdover_in(holdover_in),
  .ref0_loss_in(ref0_loss_in), .ref1_loss_in(ref1_loss_in),
  .clock_out_enable_valid_out(clock_out_enable_valid_out),
  .manual_reference_choice_out(manual_reference_choice_out),
  .manual_reference_valid_out(manual_reference_valid_out));
`default_nettype wire

// ### gpfm_general_pin_function_mux_tb.sv
// gpfm_general_pin_function_mux_tb.sv: self-checking bench for the pin function mux
// assumes: board model resolves the pin wires; checker bound separately
`timescale 1ns/1ps
`default_nettype none
module gpfm_general_pin_function_mux_tb;
  typedef struct packed {logic [2:0] code; logic [3:0] flg; logic [3:0] val; logic [3:0] pin;} gpfm_row_s;
  logic       clock_in = 1'b0, rst_n_in = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ref_c, ref_v;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata, en, en_v;
  logic [3:0] pin_in, pin_out, oe, drive = 4'h0, flg = 4'h0;
  int         mismatches = 0, tests_run = 0;
  gpfm_row_s  rows[5] = '{'{3'h0, 4'hF, 4'hA, 4'hA}, '{3'h1, 4'h8, 4'h0, 4'h1}, '{3'h1, 4'h7, 4'h0, 4'h6},
                          '{3'h2, 4'hF, 4'h0, 4'hC}, '{3'h5, 4'hF, 4'hF, 4'h0}};
  always #20 clock_in = ~clock_in;
  gpfm_general_pin_function_mux DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(oe), .loss_of_lock_in(flg[3]), .holdover_in(flg[2]), .ref0_loss_in(flg[1]),
    .ref1_loss_in(flg[0]), .clock_out_enable_out(en), .clock_out_enable_valid_out(en_v),
    .manual_reference_choice_out(ref_c), .manual_reference_valid_out(ref_v));
  gpfm_board u_board (.dev_level_in(pin_out), .dev_enable_in(oe), .drive_in(drive), .wire_level_out(pin_in));
  // ==========================================================================
  // bus and compare tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic settle;
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task automatic put(input logic [3:0] d);
    @(posedge clock_in);
    drive <= d;
    settle;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_in);
    mismatches++;
    report_and_stop;
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (int a = 'h6E; a <= 'h76; a++) rd(12'(a), 8'h00);
    wr(12'h075, 8'h00);
    rd(12'h075, 8'h00);
    put(4'hA);
    rd(12'h219, 8'h0A);
    $display("test reset done");
    wr(12'h06E, 8'h0F);
    foreach (rows[i]) begin
      wr(12'h072, {4'h0, {4{rows[i].code[2]}}});
      wr(12'h073, {4'h0, {4{rows[i].code[1]}}});
      wr(12'h074, {4'h0, {4{rows[i].code[0]}}});
      wr(12'h076, {4'h0, rows[i].val});
      @(posedge clock_in);
      flg <= rows[i].flg;
      settle;
      chk("pin_out", {4'h0, rows[i].pin}, {4'h0, pin_out});
      chk("pin_oe", 8'h0F, {4'h0, oe});
      rd(12'h076, {4'h0, rows[i].val});
    end
    $display("test outputs done");
    wr(12'h06E, 8'h00);
    wr(12'h071, 8'h0F);
    put(4'h5);
    chk("en_valid", 8'h0F, en_v);
    chk("en_low", 8'h05, {4'h0, en[3:0]});
    // level bits hold what was last seen as general input: the driven zeros
    rd(12'h219, 8'h00);
    wr(12'h06E, 8'h0F);
    settle;
    chk("en_valid", 8'h00, en_v);
    wr(12'h06E, 8'h00);
    wr(12'h071, 8'h00);
    wr(12'h070, 8'h0F);
    settle;
    chk("en_valid", 8'hF0, en_v);
    chk("en_high", 8'h50, {en[7:4], 4'h0});
    wr(12'h06F, 8'h0F);
    wr(12'h070, 8'h00);
    wr(12'h071, 8'h0F);
    settle;
    chk("en_valid", 8'h00, en_v);
    chk("ref", 8'h03, {6'h00, ref_v, ref_c});
    put(4'h0);
    chk("ref", 8'h02, {6'h00, ref_v, ref_c});
    wr(12'h06E, 8'h04);
    put(4'hF);
    chk("ref", 8'h00, {6'h00, ref_v, ref_c});
    $display("test inputs done");
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    settle;
    chk("en_valid", 8'h00, en_v);
    rd(12'h06E, 8'h00);
    rd(12'h219, 8'h0F);
    $display("test second reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// ### gpfm_pin_sync.sv
// gpfm_pin_sync.sv: two-stage synchroniser for the four pin input levels
// assumes: pins are asynchronous to clock_in; one synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module gpfm_pin_sync
  import gpfm_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  always_comb begin
    nxt_stage1 = async_in;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign sync_out = stage2_ff;
endmodule
`default_nettype wire

// ### gpfm_pkg.sv
// gpfm_pkg.sv: types shared by the pin function mux modules
// assumes: gpfm_defs.svh is on the include path
`include "gpfm_defs.svh"
package gpfm_pkg;
  typedef logic [11:0] gpfm_addr_t;
  typedef logic [7:0]  gpfm_data_t;
  typedef logic [3:0]  gpfm_pins_t;
  typedef logic [2:0]  gpfm_sel_t;
  typedef logic [7:0]  gpfm_clk_en_t;
endpackage
